// ### include/avdm_map.vh
`ifndef AVDM_MAP_VH
`define AVDM_MAP_VH
// Clock and timeout
`define AVDM_CLK_HZ 10000000
`define AVDM_TMO_MS 1000
`define AVDM_TMO_CYC ((`AVDM_CLK_HZ / 1000) * `AVDM_TMO_MS)
`define AVDM_CNT_W 24
// Structured VDM commands
`define AVDM_CMD_W 3
`define AVDM_CMD_DISC_ID 3'h1
`define AVDM_CMD_DISC_SVID 3'h2
`define AVDM_CMD_DISC_MODE 3'h3
`define AVDM_CMD_ENTER 3'h4
`define AVDM_CMD_EXIT 3'h5
`define AVDM_CMD_VENDOR 3'h6
// Answer types
`define AVDM_ANS_W 2
`define AVDM_ANS_ACK 2'h1
`define AVDM_ANS_NAK 2'h2
`define AVDM_ANS_BUSY 2'h3
// Packet addresses
`define AVDM_SOP_W 2
`define AVDM_SOP 2'h0
`define AVDM_SOP_P 2'h1
`define AVDM_SOP_PP 2'h2
// Role straps
`define AVDM_ROLE_DOCK 1'h0
`define AVDM_ROLE_CABLE 1'h1
// Table of supported SVIDs and modes
`define AVDM_SVID_W 16
`define AVDM_MODE_W 32
`define AVDM_NSVID 4
`define AVDM_IDX_W 2
`define AVDM_TAB_W 48
// Identity word fields
`define AVDM_ID_DUAL_BIT 0
`define AVDM_ID_CABLE_BIT 1
`define AVDM_ID_W 32
`endif

// ### design/avdm_sync.v
`timescale 1ns/100ps
`include "avdm_map.vh"
// Two-flop synchroniser for pin levels
module avdm_sync #(
  parameter W = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Levels
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta;

  // First stage feeds only the second
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ### design/avdm_tab.v
`timescale 1ns/100ps
`include "avdm_map.vh"
// SVID and mode table, loaded by the local controller, registered read
module avdm_tab (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Write port
  input wire wr_en,
  input wire [`AVDM_IDX_W-1:0] wr_idx,
  input wire [`AVDM_TAB_W-1:0] wr_data,
  // Read port
  input wire [`AVDM_IDX_W-1:0] rd_idx,
  output reg [`AVDM_TAB_W-1:0] rd_data
);
  reg [`AVDM_TAB_W-1:0] mem [0:`AVDM_NSVID-1];

  // Storage has no reset; empty entries are marked by a zero SVID
  always @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Read data out of a register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= {`AVDM_TAB_W{1'b0}};
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule

// ### design/avdm_resp.v
`timescale 1ns/100ps
`include "avdm_map.vh"
// How it works
// - Billboard on within 1000 ms without mode
// - Answer identity, SVID and mode discovery with ACK
// - No Enter Mode: timeout then Billboard
// - Enter Mode with VID and mode ACKed
// - Mode holds until exit, detach, reset, VBUS
// - Billboard optionally kept while in mode
// - Single-controller cable answers only SOP prime
// - Identity reports SOP prime only or both
// - Dual-controller cable plugs uniquely assigned
// - Swaps never change plug assignment
// - Cable starts in default USB operation
// - Cable messages never on SOP
// - Vendor VDMs passed to vendor logic
// - Cable identity starts on SOP prime
// - Cable discovery and mode commands start SOP prime
// - Cable returns supported SVID list
// - Cable returns modes per SVID
// - Cable enters mode only on Enter Mode
// - Exit Mode returns cable to USB
// - Late Enter Mode ACKed, Billboard withdrawn; kept instead when keep_bb_strap is set
module avdm_resp #(
  parameter TMO_CYC = `AVDM_TMO_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Pin levels from the port
  input wire attach_pin,
  input wire vbus_pin,
  input wire hard_reset_pin,
  // Straps: role, dual controller, which plug this end is, keep billboard
  input wire role_strap,
  input wire dual_strap,
  input wire far_plug_strap,
  input wire keep_bb_strap,
  // Local table load port
  input wire tab_wr,
  input wire [`AVDM_IDX_W-1:0] tab_idx,
  input wire [`AVDM_TAB_W-1:0] tab_data,
  // Decoded request from the message layer
  input wire req_valid,
  input wire [`AVDM_SOP_W-1:0] req_sop,
  input wire [`AVDM_CMD_W-1:0] req_cmd,
  input wire [`AVDM_SVID_W-1:0] req_svid,
  input wire [`AVDM_MODE_W-1:0] req_mode,
  // Answer to the message layer
  output reg ans_valid,
  output reg [`AVDM_SOP_W-1:0] ans_sop,
  output reg [`AVDM_ANS_W-1:0] ans_type,
  output reg [`AVDM_MODE_W-1:0] ans_data,
  output reg ans_last,
  // Vendor request pulse
  output reg vendor_req,
  // State
  output reg mode_active,
  output reg [`AVDM_SVID_W-1:0] mode_svid,
  output reg [`AVDM_MODE_W-1:0] mode_sel,
  output reg billboard_en,
  output reg tmo_expired
);
  localparam S_IDLE = 3'h0;
  localparam S_LOOK = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_LIST = 3'h3;
  localparam S_DONE = 3'h4;

  wire attach_s;
  wire vbus_s;
  wire hreset_s;
  wire [`AVDM_TAB_W-1:0] rd_data;
  reg [2:0] state;
  reg [`AVDM_CMD_W-1:0] cmd;
  reg [`AVDM_SOP_W-1:0] sop;
  reg [`AVDM_SVID_W-1:0] svid;
  reg [`AVDM_MODE_W-1:0] mode;
  reg [`AVDM_IDX_W-1:0] idx;
  reg [`AVDM_CNT_W-1:0] cnt;
  reg role;
  reg dual;
  reg plug_pp;
  reg keep_bb;
  reg straps_ok;
  reg prime_seen;
  reg ident_done;
  reg found;
  wire link_up;
  wire [`AVDM_CNT_W-1:0] tmo_lim;

  assign tmo_lim = TMO_CYC[`AVDM_CNT_W-1:0];
  // Attached with VBUS and not in hard reset
  assign link_up = attach_s & vbus_s & ~hreset_s;

  avdm_sync #(
    .W(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({attach_pin, vbus_pin, hard_reset_pin}),
    .sync_out({attach_s, vbus_s, hreset_s})
  );

  avdm_tab u_tab (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(tab_wr),
    .wr_idx(tab_idx),
    .wr_data(tab_data),
    .rd_idx(idx),
    .rd_data(rd_data)
  );

  // Address this end answers on
  function [`AVDM_SOP_W-1:0] own_sop;
    input r;
    input p;
    begin
      if (r == `AVDM_ROLE_DOCK) begin
        own_sop = `AVDM_SOP;
      end else if (p) begin
        own_sop = `AVDM_SOP_PP;
      end else begin
        own_sop = `AVDM_SOP_P;
      end
    end
  endfunction

  // Whether a command needs a table search
  function needs_tab;
    input [`AVDM_CMD_W-1:0] c;
    begin
      needs_tab = (c == `AVDM_CMD_DISC_SVID) | (c == `AVDM_CMD_DISC_MODE) |
        (c == `AVDM_CMD_ENTER);
    end
  endfunction

  // Straps caught once after reset release; swaps cannot move them
  // assignment held fixed
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      straps_ok <= 1'b0;
      role <= 1'b0;
      dual <= 1'b0;
      plug_pp <= 1'b0;
      keep_bb <= 1'b0;
    end else if (!straps_ok) begin
      straps_ok <= 1'b1;
      role <= role_strap;
      dual <= dual_strap;
      // single controller stays on SOP prime
      plug_pp <= dual_strap & far_plug_strap;
      keep_bb <= keep_bb_strap;
    end
  end

  // Mode-entry timer from attach
  // timer start and clear
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= {`AVDM_CNT_W{1'b0}};
      tmo_expired <= 1'b0;
    end else if (!link_up || mode_active) begin
      cnt <= {`AVDM_CNT_W{1'b0}};
      tmo_expired <= 1'b0;
    end else if (cnt < tmo_lim - 1'b1) begin
      cnt <= cnt + 1'b1;
    end else begin
      // Counter parks one below the limit, so the flag stays set until entry or
      // link loss; a long wait never wraps back to a fresh timeout
      // expiry without Enter Mode
      tmo_expired <= 1'b1;
    end
  end

  // Billboard for docks only
  // Registered so the output comes straight from a flip-flop
  // billboard after timeout
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      billboard_en <= 1'b0;
    end else begin
      billboard_en <= link_up && role == `AVDM_ROLE_DOCK && straps_ok &&
        (mode_active ? keep_bb : tmo_expired);
    end
  end

  // Command interpreter; one request in flight, others dropped while busy
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      cmd <= {`AVDM_CMD_W{1'b0}};
      sop <= `AVDM_SOP;
      svid <= {`AVDM_SVID_W{1'b0}};
      mode <= {`AVDM_MODE_W{1'b0}};
      idx <= {`AVDM_IDX_W{1'b0}};
      found <= 1'b0;
      prime_seen <= 1'b0;
      ident_done <= 1'b0;
      ans_valid <= 1'b0;
      ans_sop <= `AVDM_SOP;
      ans_type <= `AVDM_ANS_NAK;
      ans_data <= {`AVDM_MODE_W{1'b0}};
      ans_last <= 1'b0;
      vendor_req <= 1'b0;
      mode_active <= 1'b0;
      mode_svid <= {`AVDM_SVID_W{1'b0}};
      mode_sel <= {`AVDM_MODE_W{1'b0}};
    end else if (!link_up) begin
      // detach, hard reset or VBUS loss ends the mode
      // Table and straps survive; only the link state is dropped
      state <= S_IDLE;
      mode_active <= 1'b0;
      prime_seen <= 1'b0;
      ident_done <= 1'b0;
      ans_valid <= 1'b0;
      vendor_req <= 1'b0;
    end else begin
      ans_valid <= 1'b0;
      vendor_req <= 1'b0;
      // any SOP prime traffic on the wire opens the double-prime plug
      // even when it is addressed to the other plug of the cable
      if (req_valid && req_sop == `AVDM_SOP_P) begin
        prime_seen <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          if (req_valid && straps_ok && req_sop == own_sop(role, plug_pp)) begin
            cmd <= req_cmd;
            sop <= req_sop;
            svid <= req_svid;
            mode <= req_mode;
            idx <= {`AVDM_IDX_W{1'b0}};
            found <= 1'b0;
            state <= needs_tab(req_cmd) ? S_WAIT : S_DONE;
          end
        end
        S_WAIT: begin
          // Let the registered table read settle
          state <= S_LOOK;
        end
        S_LOOK: begin
          if (cmd == `AVDM_CMD_DISC_SVID) begin
            state <= S_LIST;
          end else if (rd_data[`AVDM_TAB_W-1:`AVDM_MODE_W] == svid &&
                       svid != {`AVDM_SVID_W{1'b0}} &&
                       (cmd == `AVDM_CMD_DISC_MODE ||
                        rd_data[`AVDM_MODE_W-1:0] == mode)) begin
            found <= 1'b1;
            state <= S_DONE;
          end else if (idx == `AVDM_NSVID - 1) begin
            state <= S_DONE;
          end else begin
            idx <= idx + 1'b1;
            state <= S_WAIT;
          end
        end
        S_LIST: begin
          // one ACK per table entry, empty entries included, last flagged
          ans_valid <= 1'b1;
          ans_sop <= sop;
          ans_type <= `AVDM_ANS_ACK;
          ans_data <= {{(`AVDM_MODE_W-`AVDM_SVID_W){1'b0}},
                       rd_data[`AVDM_TAB_W-1:`AVDM_MODE_W]};
          ans_last <= (idx == `AVDM_NSVID - 1);
          if (idx == `AVDM_NSVID - 1) begin
            state <= S_IDLE;
          end else begin
            idx <= idx + 1'b1;
            state <= S_WAIT;
          end
        end
        S_DONE: begin
          ans_valid <= 1'b1;
          ans_sop <= sop;
          ans_last <= 1'b1;
          ans_type <= `AVDM_ANS_NAK;
          ans_data <= {`AVDM_MODE_W{1'b0}};
          state <= S_IDLE;
          // other commands also after SOP prime
          if (role == `AVDM_ROLE_CABLE && sop == `AVDM_SOP_PP && !prime_seen) begin
            ans_type <= `AVDM_ANS_BUSY;
          end else begin
            case (cmd)
              `AVDM_CMD_DISC_ID: begin
                ans_type <= `AVDM_ANS_ACK;
                ans_data[`AVDM_ID_DUAL_BIT] <= dual;
                ans_data[`AVDM_ID_CABLE_BIT] <= role;
                ident_done <= 1'b1;
              end
              `AVDM_CMD_DISC_MODE: begin
                if (found) begin
                  ans_type <= `AVDM_ANS_ACK;
                  ans_data <= rd_data[`AVDM_MODE_W-1:0];
                end
              end
              `AVDM_CMD_ENTER: begin
                if (found && ident_done) begin
                  ans_type <= `AVDM_ANS_ACK;
                  mode_active <= 1'b1;
                  mode_svid <= svid;
                  mode_sel <= mode;
                end
              end
              `AVDM_CMD_EXIT: begin
                if (mode_active && svid == mode_svid) begin
                  ans_type <= `AVDM_ANS_ACK;
                  mode_active <= 1'b0;
                end
              end
              `AVDM_CMD_VENDOR: begin
                ans_type <= `AVDM_ANS_ACK;
                vendor_req <= 1'b1;
                ans_data <= mode;
              end
              default: begin
                ans_type <= `AVDM_ANS_NAK;
              end
            endcase
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ### verif/avdm_host.sv
`timescale 1ns/100ps
`include "avdm_map.vh"
// Host port model: link pins and one request at a time
module avdm_host (
  // Clock
  input wire sys_clk,
  // Link pins
  output reg attach_pin,
  output reg vbus_pin,
  output reg hard_reset_pin,
  // Request
  output reg req_valid,
  output reg [`AVDM_SOP_W-1:0] req_sop,
  output reg [`AVDM_CMD_W-1:0] req_cmd,
  output reg [`AVDM_SVID_W-1:0] req_svid,
  output reg [`AVDM_MODE_W-1:0] req_mode
);
  initial begin
    {attach_pin, vbus_pin, hard_reset_pin, req_valid} = 4'h0;
    {req_sop, req_cmd, req_svid, req_mode} = 53'h0;
  end
  task link(input up);
    begin
      @(negedge sys_clk) attach_pin = up;
      repeat (2) @(negedge sys_clk);
      vbus_pin = up;
      repeat (4) @(negedge sys_clk);
    end
  endtask
  task send(input [1:0] s, input [2:0] c, input [15:0] v, input [31:0] m);
    begin
      @(negedge sys_clk);
      {req_valid, req_sop, req_cmd, req_svid, req_mode} = {1'h1, s, c, v, m};
      @(negedge sys_clk) req_valid = 1'h0;
      // Idle lines carry junk so a late capture shows
      {req_svid, req_mode} = ~{req_svid, req_mode};
    end
  endtask
endmodule

// ### verif/avdm_resp_monitor.sv
`timescale 1ns/100ps
`include "avdm_map.vh"
// Answer and mode checks at the responder ports
module avdm_resp_monitor (
  input wire sys_clk,
  input wire rst,
  input wire role_strap,
  input wire keep_bb_strap,
  input wire ans_valid,
  input wire [`AVDM_SOP_W-1:0] ans_sop,
  input wire [`AVDM_ANS_W-1:0] ans_type,
  input wire vendor_req,
  input wire mode_active,
  input wire billboard_en,
  input wire tmo_expired
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_ack;
    ans_valid && ans_type == `AVDM_ANS_ACK;
  endsequence
  sequence s_enter;
    s_ack ##0 $rose(mode_active);
  endsequence
  enter_ack_a: assert property ($rose(mode_active) |-> s_ack)
    else $error("mode set without ack");
  bb_keep_a: assert property (s_enter |=> billboard_en == (keep_bb_strap && !role_strap))
    else $error("billboard wrong after entry");
  bb_tmo_a: assert property ($rose(billboard_en) && !mode_active |-> $past(tmo_expired))
    else $error("billboard before timeout");
  cable_bb_a: assert property (role_strap |-> !billboard_en)
    else $error("cable shows billboard");
  tmo_mode_a: assert property ($rose(tmo_expired) |-> !mode_active)
    else $error("timeout while in mode");
  sop_match_a: assert property (ans_valid |-> (ans_sop == `AVDM_SOP) == !role_strap)
    else $error("answer on wrong address");
  vendor_ans_a: assert property (vendor_req |-> ans_valid)
    else $error("vendor pulse alone");
  ans_pulse_a: assert property (ans_valid |=> !ans_valid)
    else $error("answer held two cycles");
  exit_ack_a: assert property ($fell(mode_active) && ans_valid |-> s_ack)
    else $error("exit without ack");
endmodule
bind avdm_resp avdm_resp_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
  .role_strap(role_strap), .keep_bb_strap(keep_bb_strap), .ans_valid(ans_valid),
  .ans_sop(ans_sop), .ans_type(ans_type), .vendor_req(vendor_req),
  .mode_active(mode_active), .billboard_en(billboard_en), .tmo_expired(tmo_expired));

// ### verif/avdm_resp_tb.sv
`timescale 1ns/100ps
`include "avdm_map.vh"
module avdm_resp_tb;
  reg sys_clk = 1'h0;
  reg rst = 1'h1;
  reg [3:0] strap = 4'h0;
  reg tab_wr = 1'h0;
  reg [1:0] tab_idx = 2'h0;
  reg [47:0] tab_data = 48'h0;
  wire att, vb, hr, rv, av, al, vr, ma, bb, te;
  wire [1:0] rs, at;
  wire [2:0] rc;
  wire [15:0] sv, ms;
  wire [31:0] rm, ad, md;
  integer n_errors = 0;
  integer tests_run = 0;
  integer i;
  integer j;
  // Clock 10 MHz
  always #50 sys_clk = ~sys_clk;
  avdm_host u_host (.sys_clk(sys_clk), .attach_pin(att), .vbus_pin(vb), .hard_reset_pin(hr),
    .req_valid(rv), .req_sop(rs), .req_cmd(rc), .req_svid(sv), .req_mode(rm));
  // Short timeout keeps the run brief
  avdm_resp #(.TMO_CYC(50)) u_dut (.sys_clk(sys_clk), .rst(rst), .attach_pin(att),
    .vbus_pin(vb), .hard_reset_pin(hr), .role_strap(strap[3]), .dual_strap(strap[2]),
    .far_plug_strap(strap[1]), .keep_bb_strap(strap[0]), .tab_wr(tab_wr), .tab_idx(tab_idx),
    .tab_data(tab_data), .req_valid(rv), .req_sop(rs), .req_cmd(rc), .req_svid(sv),
    .req_mode(rm), .ans_valid(av), .ans_sop(), .ans_type(at), .ans_data(ad), .ans_last(al),
    .vendor_req(vr), .mode_active(ma), .mode_svid(ms), .mode_sel(md), .billboard_en(bb),
    .tmo_expired(te));
  task check(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t %h %h", $time, got, exp);
      end
    end
  endtask
  // Wait for one answer; type 0 marks a vendor answer
  task ans(input [1:0] t, input [31:0] d, input [31:0] mk);
    begin
      i = 0;
      while (av !== 1'h1 && i < 30) begin
        @(negedge sys_clk);
        i = i + 1;
      end
      check(av, 1'h1);
      check(vr, t == 2'h0);
      if (t != 2'h0) check(at, t);
      check(ad & mk, d);
      @(negedge sys_clk);
    end
  endtask
  task x(input [1:0] s, input [2:0] c, input [15:0] v, input [31:0] m, input [1:0] t,
    input [31:0] d, input [31:0] mk);
    begin
      u_host.send(s, c, v, m);
      ans(t, d, mk);
    end
  endtask
  // A request the block must ignore gets no answer
  task y(input [1:0] s);
    begin
      u_host.send(s, `AVDM_CMD_DISC_ID, 16'h0, 32'h0);
      repeat (15) @(negedge sys_clk) check(av, 1'h0);
    end
  endtask
  task restart(input [3:0] s);
    begin
      rst = 1'h1;
      strap = s;
      u_host.hard_reset_pin = 1'h0;
      u_host.link(1'h0);
      // Link teardown above already spent seven of the eight reset cycles
      repeat (1) @(negedge sys_clk);
      rst = 1'h0;
      // Entries 1 and 3 stay empty so the search must skip them
      for (i = 0; i < 4; i = i + 1) begin
        @(negedge sys_clk) tab_wr = 1'h1;
        tab_idx = i[1:0];
        tab_data = (i == 0) ? 48'hA5C3_0000_0011 : (i == 2) ? 48'h5A3C_0000_0405 : 48'h0;
        @(negedge sys_clk) tab_wr = 1'h0;
      end
      u_host.link(1'h1);
    end
  endtask
  task svids(input [1:0] s);
    begin
      u_host.send(s, `AVDM_CMD_DISC_SVID, 16'h0, 32'h0);
      for (j = 0; j < 4; j = j + 1) begin
        ans(`AVDM_ANS_ACK, (j == 0) ? 32'hA5C3 : (j == 2) ? 32'h5A3C : 32'h0, 32'hFFFF);
        check(al, j == 3);
      end
    end
  endtask
  task t_dock;
    begin
      restart(4'h0);
      check({te, bb}, 2'h0);
      x(`AVDM_SOP, `AVDM_CMD_DISC_ID, 16'h0, 32'h0, `AVDM_ANS_ACK, 32'h0, 32'h3);
      svids(`AVDM_SOP);
      x(`AVDM_SOP, `AVDM_CMD_DISC_MODE, 16'h5A3C, 32'h0, `AVDM_ANS_ACK, 32'h405, ~32'h0);
      x(`AVDM_SOP, `AVDM_CMD_DISC_MODE, 16'h1111, 32'h0, `AVDM_ANS_NAK, 32'h0, 32'h0);
      for (i = 0; i < 200 && bb !== 1'h1; i = i + 1) @(negedge sys_clk);
      check({te, bb, ma}, 3'h6);
      x(`AVDM_SOP, `AVDM_CMD_ENTER, 16'h5A3C, 32'h405, `AVDM_ANS_ACK, 32'h0, 32'h0);
      check({ma, ms}, {1'h1, 16'h5A3C});
      check(md, 32'h405);
      @(negedge sys_clk) check(bb, 1'h0);
      x(`AVDM_SOP, `AVDM_CMD_EXIT, 16'hA5C3, 32'h11, `AVDM_ANS_NAK, 32'h0, 32'h0);
      check(ma, 1'h1);
      x(`AVDM_SOP, `AVDM_CMD_EXIT, 16'h5A3C, 32'h405, `AVDM_ANS_ACK, 32'h0, 32'h0);
      check(ma, 1'h0);
      x(`AVDM_SOP, `AVDM_CMD_ENTER, 16'h5A3C, 32'h405, `AVDM_ANS_ACK, 32'h0, 32'h0);
      u_host.hard_reset_pin = 1'h1;
      repeat (6) @(negedge sys_clk);
      check(ma, 1'h0);
      check(te, 1'h0);
    end
  endtask
  task t_cable;
    begin
      restart(4'h8);
      check(ma, 1'h0);
      y(`AVDM_SOP);
      y(`AVDM_SOP_PP);
      x(`AVDM_SOP_P, `AVDM_CMD_ENTER, 16'h5A3C, 32'h405, `AVDM_ANS_NAK, 32'h0, 32'h0);
      x(`AVDM_SOP_P, `AVDM_CMD_DISC_ID, 16'h0, 32'h0, `AVDM_ANS_ACK, 32'h2, 32'h3);
      x(`AVDM_SOP_P, `AVDM_CMD_VENDOR, 16'h0, 32'h0, 2'h0, 32'h0, 32'h0);
      svids(`AVDM_SOP_P);
      x(`AVDM_SOP_P, `AVDM_CMD_DISC_MODE, 16'hA5C3, 32'h0, `AVDM_ANS_ACK, 32'h11, ~32'h0);
      x(`AVDM_SOP_P, `AVDM_CMD_ENTER, 16'hA5C3, 32'h11, `AVDM_ANS_ACK, 32'h0, 32'h0);
      check({ma, ms}, {1'h1, 16'hA5C3});
      x(`AVDM_SOP_P, `AVDM_CMD_EXIT, 16'hA5C3, 32'h11, `AVDM_ANS_ACK, 32'h0, 32'h0);
      check(ma, 1'h0);
      // Far plug of a dual cable answers only its own address
      restart(4'hE);
      x(`AVDM_SOP_PP, `AVDM_CMD_DISC_ID, 16'h0, 32'h0, `AVDM_ANS_BUSY, 32'h0, 32'h0);
      y(`AVDM_SOP_P);
      x(`AVDM_SOP_PP, `AVDM_CMD_DISC_ID, 16'h0, 32'h0, `AVDM_ANS_ACK, 32'h3, 32'h3);
      // Dock that keeps its billboard while in mode
      restart(4'h1);
      x(`AVDM_SOP, `AVDM_CMD_DISC_ID, 16'h0, 32'h0, `AVDM_ANS_ACK, 32'h0, 32'h3);
      x(`AVDM_SOP, `AVDM_CMD_ENTER, 16'hA5C3, 32'h11, `AVDM_ANS_ACK, 32'h0, 32'h0);
      @(negedge sys_clk) check(bb, 1'h1);
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    t_dock;
    t_cable;
    complete_run;
  end
  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    repeat (8000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    complete_run;
  end
endmodule
